// ==== include/line_master_defs.svh ====
// Purpose: constants of the series line master auxiliary logic
// Assumes: 100 MHz clock
// Notes: offsets are service-data indices
`ifndef LINE_MASTER_DEFS_SVH
`define LINE_MASTER_DEFS_SVH
`define LM_NODES 32
`define LM_POSITIONS 33
`define LM_IDX_COMM_STATE 16'h0113
`define LM_IDX_NODE_TOTAL 16'h0114
`define LM_EVT_CUTOFF 16'h1800
`define LM_STORE_CMD 8'h03
`define LM_CLK_HZ 100000000
`define LM_FLASH1_HZ 1
`define LM_FLASH2_HZ 2
`define LM_FLASH1_HALF ((`LM_CLK_HZ) / (2 * `LM_FLASH1_HZ))
`define LM_FLASH2_HALF ((`LM_CLK_HZ) / (2 * `LM_FLASH2_HZ))
`define LM_PD_CYCLES 2
`define LM_FIFO_DEPTH 8
`define LM_CFG_W 6
`define LM_CFG_RESET 6'h0_00C
`define LM_MCFG_RESET 4'h0
`define LM_CS_INTERRUPTED 8'h00
`define LM_CS_INIT 8'h01
`define LM_CS_RUNNING 8'h03
`define LM_CS_OPEN 8'h06
`define LM_CS_CFG_ERR 8'h07
`endif

// ==== include/line_master_pkg.sv ====
// Purpose: types of the series line master auxiliary logic
// Assumes: nothing
// Notes: constants live in line_master_defs.svh
package line_master_pkg;
  // per-position configuration entry, one per node or terminator
  typedef struct packed {
    logic flash2;
    logic flash1;
    logic fwd_en;   // input_forward_enable
    logic link_en;  // output_link_enable
    logic mon_off;  // output monitoring deactivated
    logic used;
  } node_cfg_s;
  typedef enum logic [3:0] {
    ST_WAIT_CFG = 4'b0001,
    ST_CHECK    = 4'b0010,
    ST_RUN      = 4'b0100,
    ST_ERROR    = 4'b1000
  } line_state_e;
  typedef logic [31:0] pd_word_t;
endpackage

// ==== include/pd_stream_if.sv ====
// Purpose: valid/ready word stream between line master and its fifo
// Assumes: one clock
// Notes: none
`timescale 1ns/1ns
interface pd_stream_if #(parameter int W = 32);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ==== verilog/pd_fifo.sv ====
// Purpose: small synchronous fifo for cyclic output words
// Assumes: single clock, clock enable freezes state
// Notes: width and depth are parameters, depth a power of two
`timescale 1ns/1ns
module pd_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 8
) (
  input wire logic i_clk,        // clock
  input wire logic i_reset_n,    // async reset, low
  input wire logic i_ce,         // clock enable
  pd_stream_if.snk wr,           // filling side
  pd_stream_if.src rd            // draining side
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wp_q, rp_q;
  wire full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
  wire empty = (wp_q == rp_q);
  wire push = i_ce && wr.valid && !full;
  wire pop = i_ce && rd.ready && !empty;
  assign wr.ready = !full;
  assign rd.valid = !empty;
  assign rd.data = mem[rp_q[AW-1:0]];
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wp_q[AW-1:0]] <= wr.data;
    end
  end
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop) rp_q <= rp_q + 1'b1;
    end
  end
  a_fifo_no_overrun: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    full |-> !push) else $error("fifo pushed while full");
endmodule

// ==== verilog/line_master_aux.sv ====
// Purpose: auxiliary signal logic of a series line master
// Assumes: node and line signals are asynchronous pins
// Notes: configuration takes effect only on store
//
// Function
// (R01) coupled node output holds while input switched
// (R02) monitoring off frees output from input
// (R03) one config entry per 33 line positions
// (R04) factory default ORs all node inputs
// (R05) forwarding off excludes node input
// (R06) node output is pd bit OR master input
// (R07) link off removes master input from output
// (R08) flash modes toggle output at 1/2 Hz
// (R09) commissioning mode waits for new configuration
// (R10) ignore count skips node number check
// (R11) ignore types skips node type check
// (R12) common logic AND when true, else OR
// (R13) cut-off event while any shutdown or error
// (R14) input word bit0 node32, bit31 node1
// (R15) output word bit set activates node output
// (R16) process data exchanged once per cycle
// (R17) response spans two cycles of transfer
// (R18) comm state at index 0x113 with codes
// (R19) node total at index 0x114
// (R20) settings apply only after store command
// (R21) event signalled then read by master
// (R22) flashing about half duty, stops at once
`timescale 1ns/1ns
`include "line_master_defs.svh"
module line_master_aux #(
  parameter int NODES = `LM_NODES,
  parameter int FLASH1_HALF = `LM_FLASH1_HALF,
  parameter int FLASH2_HALF = `LM_FLASH2_HALF
) (
  input wire logic i_clk,                     // 100 MHz clock
  input wire logic i_reset_n,                 // async reset, low
  input wire logic i_ce,                      // clock enable
  input wire logic [NODES-1:0] i_node_aux_in, // node aux inputs, index 0 = node 1
  output logic [NODES-1:0] o_node_aux_out,    // node aux outputs
  input wire logic i_master_aux_in,           // master aux input pin
  output logic o_master_aux_out,              // master aux output pin
  input wire logic [NODES-1:0] i_node_fault,  // shutdown or error per node
  input wire logic [NODES-1:0] i_node_present,// node detected per node
  input wire logic i_type_ok,                 // node types match config
  input wire logic i_line_closed,             // terminator seen
  input wire logic i_link_up,                 // line communication alive
  input wire logic i_pd_cycle,                // one pulse per comm cycle
  input wire line_master_pkg::pd_word_t i_pd_out,  // host output word
  output line_master_pkg::pd_word_t o_pd_in,       // device input word
  input wire logic i_cfg_we,                  // config entry write
  input wire logic [5:0] i_cfg_pos,           // position 0..32
  input wire line_master_pkg::node_cfg_s i_cfg_data, // entry value
  input wire logic i_mcfg_we,                 // master settings write
  input wire logic [3:0] i_mcfg_data,         // and,ign_type,ign_cnt,commission
  input wire logic i_store,                   // system command strobe
  input wire logic [7:0] i_store_cmd,         // system command code
  input wire logic i_idx_rd,                  // index read strobe
  input wire logic [15:0] i_idx,              // index number
  output logic [7:0] o_idx_data,              // index read data
  output logic o_idx_valid,                   // index read answer
  output logic o_event_req,                   // event pending to master
  output logic [15:0] o_event_code,           // event code
  output logic o_event_present,               // event appears/disappears
  input wire logic i_event_ack,               // master has read event
  output logic o_pd_ready                     // host word accepted
);
  import line_master_pkg::*;

  // ================================================================
  // pin synchronisers
  logic [NODES-1:0] nin_s1_q, nin_q;
  logic [NODES-1:0] flt_s1_q, flt_q, prs_s1_q, prs_q;
  logic [4:0] pin_s1_q, pin_q;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      nin_s1_q <= '0;
      nin_q <= '0;
      flt_s1_q <= '0;
      flt_q <= '0;
      prs_s1_q <= '0;
      prs_q <= '0;
      pin_s1_q <= '0;
      pin_q <= '0;
    end else if (i_ce) begin
      nin_s1_q <= i_node_aux_in;
      nin_q <= nin_s1_q;
      flt_s1_q <= i_node_fault;
      flt_q <= flt_s1_q;
      prs_s1_q <= i_node_present;
      prs_q <= prs_s1_q;
      pin_s1_q <= {i_master_aux_in, i_type_ok, i_line_closed, i_link_up, 1'b0};
      pin_q <= pin_s1_q;
    end
  end
  wire m_in = pin_q[4];
  wire type_ok = pin_q[3];
  wire closed = pin_q[2];
  wire link_up = pin_q[1];

  // ================================================================
  // configuration: pending copy written by host, active copy on store
  node_cfg_s pend_q [`LM_POSITIONS];
  node_cfg_s act_q [`LM_POSITIONS]; // (R03)
  logic [3:0] mpend_q, mact_q;
  wire store_hit = i_store && (i_store_cmd == `LM_STORE_CMD); // (R20)
  genvar g;
  generate
    for (g = 0; g < `LM_POSITIONS; g++) begin : g_cfg
      always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          pend_q[g] <= `LM_CFG_RESET; // (R04)
          act_q[g] <= `LM_CFG_RESET;
        end else if (i_ce) begin
          if (i_cfg_we && i_cfg_pos == 6'(g)) pend_q[g] <= i_cfg_data;
          if (store_hit) act_q[g] <= pend_q[g]; // (R20)
        end
      end
    end
  endgenerate
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mpend_q <= `LM_MCFG_RESET;
      mact_q <= `LM_MCFG_RESET;
    end else if (i_ce) begin
      if (i_mcfg_we) mpend_q <= i_mcfg_data;
      if (store_hit) mact_q <= mpend_q; // (R20)
    end
  end
  wire commission = mact_q[0];
  wire ign_cnt = mact_q[1];
  wire ign_type = mact_q[2];
  wire and_sel = mact_q[3]; // common_input_logic_select

  // ================================================================
  // line state machine
  line_state_e st_q, st_d;
  logic [5:0] used_cnt, pres_cnt;
  always_comb begin
    used_cnt = '0;
    pres_cnt = '0;
    for (int i = 0; i < NODES; i++) begin
      used_cnt = used_cnt + 6'(act_q[i].used);
      pres_cnt = pres_cnt + 6'(prs_q[i]);
    end
  end
  wire cnt_ok = ign_cnt || (used_cnt == pres_cnt); // (R10)
  wire typ_ok = ign_type || type_ok; // (R11)
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_WAIT_CFG: if (!commission && link_up) st_d = ST_CHECK;
      ST_CHECK: st_d = (cnt_ok && typ_ok && closed) ? ST_RUN : ST_ERROR;
      ST_RUN: if (!link_up || !closed) st_d = ST_ERROR;
      // re-check only once the fault is gone, so a config error reads steadily
      ST_ERROR: if (link_up && closed && cnt_ok && typ_ok) st_d = ST_CHECK;
      default: st_d = ST_WAIT_CFG;
    endcase
    if (commission) st_d = ST_WAIT_CFG; // (R09)
  end
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) st_q <= ST_WAIT_CFG;
    else if (i_ce) st_q <= st_d;
  end
  wire running = (st_q == ST_RUN);

  // ================================================================
  // master aux output: OR/AND over forwarded node inputs
  logic [NODES-1:0] fwd_or, fwd_and, fwd_msk;
  generate
    for (g = 0; g < NODES; g++) begin : g_fwd
      assign fwd_or[g] = nin_q[g] && act_q[g].fwd_en; // (R05)
      assign fwd_and[g] = nin_q[g] || !act_q[g].fwd_en; // (R05)
      assign fwd_msk[g] = act_q[g].fwd_en;
    end
  endgenerate
  // an all-excluded AND reads low rather than vacuously high
  wire any_fwd = |fwd_msk;
  wire m_out_d = and_sel ? ((&fwd_and) && any_fwd) : (|fwd_or); // (R12)

  // ================================================================
  // flash timebase: free running, ~50 % duty
  logic [26:0] f1_q;
  logic [25:0] f2_q;
  logic ph1_q, ph2_q;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      f1_q <= '0;
      f2_q <= '0;
      ph1_q <= 1'b0;
      ph2_q <= 1'b0;
    end else if (i_ce) begin
      f1_q <= (f1_q == 27'(FLASH1_HALF - 1)) ? '0 : f1_q + 1'b1;
      f2_q <= (f2_q == 26'(FLASH2_HALF - 1)) ? '0 : f2_q + 1'b1;
      if (f1_q == 27'(FLASH1_HALF - 1)) ph1_q <= ~ph1_q; // (R08) (R22)
      if (f2_q == 26'(FLASH2_HALF - 1)) ph2_q <= ~ph2_q; // (R08) (R22)
    end
  end

  // ================================================================
  // process data: host words pass through the fifo once per cycle
  pd_stream_if #(.W(32)) pd_wr ();
  pd_stream_if #(.W(32)) pd_rd ();
  assign pd_wr.valid = i_pd_cycle;
  assign pd_wr.data = i_pd_out;
  assign o_pd_ready = pd_wr.ready;
  assign pd_rd.ready = i_pd_cycle; // drained one word per cycle (R16)
  pd_fifo #(.W(32), .DEPTH(`LM_FIFO_DEPTH)) u_fifo (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_ce(i_ce),
    .wr(pd_wr),
    .rd(pd_rd)
  );
  pd_word_t cmd_q;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cmd_q <= '0;
      o_pd_in <= '0;
      o_master_aux_out <= 1'b0;
    end else if (i_ce) begin
      if (pd_rd.valid && pd_rd.ready) cmd_q <= pd_rd.data; // (R15) (R17)
      if (i_pd_cycle) o_pd_in <= {<<{nin_q}}; // (R14) (R16)
      o_master_aux_out <= running && m_out_d; // (R04)
    end
  end

  // ================================================================
  // node aux outputs
  logic [NODES-1:0] out_q, req;
  generate
    for (g = 0; g < NODES; g++) begin : g_out
      // bit 31 of the host word commands node 1
      assign req[g] = cmd_q[31-g] || (m_in && act_q[g].link_en); // (R06) (R07) (R15)
      wire flashed = act_q[g].flash1 ? ph1_q : (act_q[g].flash2 ? ph2_q : 1'b1);
      wire hold = !act_q[g].mon_off && nin_q[g]; // (R01) (R02)
      always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) out_q[g] <= 1'b0;
        else if (i_ce && !hold) out_q[g] <= running && req[g] && flashed; // (R08) (R22)
      end
    end
  endgenerate
  assign o_node_aux_out = out_q;

  // ================================================================
  // cut-off event toward the io-link master
  wire cut_now = |flt_q;
  logic ev_state_q;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ev_state_q <= 1'b0;
      o_event_req <= 1'b0;
      o_event_present <= 1'b0;
    end else if (i_ce) begin
      if (cut_now != ev_state_q) begin // (R13) (R21)
        ev_state_q <= cut_now;
        o_event_present <= cut_now;
        o_event_req <= 1'b1; // set wins over ack
      end else if (i_event_ack) begin
        o_event_req <= 1'b0;
      end
    end
  end
  assign o_event_code = `LM_EVT_CUTOFF; // (R13)

  // ================================================================
  // status indices
  logic [7:0] cstate;
  always_comb begin
    case (st_q)
      ST_WAIT_CFG: cstate = `LM_CS_INIT;
      ST_CHECK: cstate = `LM_CS_INIT;
      ST_RUN: cstate = `LM_CS_RUNNING;
      ST_ERROR: cstate = !link_up ? `LM_CS_INTERRUPTED :
                         (!closed ? `LM_CS_OPEN : `LM_CS_CFG_ERR);
      default: cstate = `LM_CS_INTERRUPTED;
    endcase
  end
  wire hit_cs = (i_idx == `LM_IDX_COMM_STATE); // (R18)
  wire hit_nt = (i_idx == `LM_IDX_NODE_TOTAL); // (R19)
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_idx_data <= '0;
      o_idx_valid <= 1'b0;
    end else if (i_ce) begin
      o_idx_valid <= i_idx_rd;
      if (i_idx_rd) o_idx_data <= hit_cs ? cstate : (hit_nt ? {2'b00, pres_cnt} : 8'h00);
    end
  end

  // ================================================================
  // checks
  a_store_only_apply: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (i_ce && !store_hit) |=> $stable(mact_q)) else $error("settings changed without store"); // (R20)
  a_commission_wait: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (i_ce && commission) |=> st_q == ST_WAIT_CFG) else $error("commission not waiting"); // (R09)
  a_event_raise: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (i_ce && cut_now && !ev_state_q) |=> (o_event_req && o_event_present))
    else $error("cut-off event missing"); // (R13)
  a_event_clear: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (i_ce && !cut_now && ev_state_q) |=> (o_event_req && !o_event_present))
    else $error("cut-off clear missing"); // (R21)
  a_pd_in_order: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (i_ce && i_pd_cycle) |=> o_pd_in[0] == $past(nin_q[NODES-1])) else $error("pd bit order"); // (R14)
  a_hold_coupled: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (i_ce && nin_q[0] && !act_q[0].mon_off) |=> $stable(out_q[0])) else $error("coupled output moved"); // (R01)
  a_off_when_idle: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (i_ce && !nin_q[0] && !req[0]) |=> !out_q[0]) else $error("output not off"); // (R22)
  a_master_or: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (i_ce && running && !and_sel && (fwd_or != '0)) |=> o_master_aux_out)
    else $error("master or output low"); // (R12)
  a_idx_answer: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (i_ce && i_idx_rd && hit_cs) |=> (o_idx_valid && o_idx_data == $past(cstate)))
    else $error("comm state read wrong"); // (R18)
  c_store: cover property (@(posedge i_clk) store_hit);
  c_run: cover property (@(posedge i_clk) st_q == ST_RUN);
  c_event: cover property (@(posedge i_clk) o_event_req && o_event_present);
  c_flash: cover property (@(posedge i_clk) act_q[0].flash1 && $rose(out_q[0]));
endmodule

// ==== verification/iolink_host_model.sv ====
// Purpose: behavioural controller side of the cyclic exchange and event read
// Assumes: one word per communication cycle, words applied after the falling edge
// Notes: the word lines carry the inverse of the last word outside a cycle pulse
`timescale 1ns/1ns
module iolink_host_model (
  input wire logic i_clk,                    // device clock
  input wire logic i_pd_ready,               // device accepts a word
  input wire logic i_event_req,              // event pending
  output logic o_pd_cycle,                   // cycle pulse
  output line_master_pkg::pd_word_t o_pd_out, // host output word
  output logic o_event_ack                   // event has been read
);
  import line_master_pkg::*;
  initial begin
    o_pd_cycle = 1'b0;
    o_pd_out = 32'h0000_0000;
    o_event_ack = 1'b0;
  end
  // ==========================================================
  // cyclic word, held until accepted
  task automatic send_word(input pd_word_t w);
    int n;
    n = 0;
    @(negedge i_clk);
    o_pd_cycle = 1'b1;
    o_pd_out = w;
    @(posedge i_clk);
    while (i_pd_ready !== 1'b1 && n < 16) begin
      n++;
      @(posedge i_clk);
    end
    @(negedge i_clk);
    o_pd_cycle = 1'b0;
    o_pd_out = ~w;
  endtask
  // ==========================================================
  // wait for a signalled event, then read it
  task automatic take_event(output logic seen);
    int n;
    n = 0;
    seen = 1'b0;
    while (i_event_req !== 1'b1 && n < 32) begin
      n++;
      @(negedge i_clk);
    end
    seen = (i_event_req === 1'b1);
    @(negedge i_clk);
    o_event_ack = seen;
    @(negedge i_clk);
    o_event_ack = 1'b0;
  endtask
endmodule

// ==== verification/tb_series_line_master_aux_logic.sv ====
// Purpose: self-checking bench of the line master auxiliary logic
// Assumes: flash half periods shortened to 8 and 4 cycles
// Notes: pins pass two sync stages, so checks wait a few cycles after a pin change
`timescale 1ns/1ns
`include "line_master_defs.svh"
module tb_series_line_master_aux_logic;
  import line_master_pkg::*;
  logic clk, rst_n, ce, m_in, cfg_we, mcfg_we, stor, idx_rd, type_ok, closed, link_up;
  logic [31:0] n_in, fault, present;
  logic [5:0] pos;
  node_cfg_s cdat;
  logic [3:0] mdat;
  logic [7:0] scmd, rd, idx_q;
  logic [15:0] idx;
  logic [31:0] n_out;
  logic m_out, pd_cyc, pd_rdy, idx_v, ev_req, ev_pres, ev_ack, seen;
  pd_word_t pd_out, pd_in;
  logic [15:0] ev_code;
  int err_total, checked, cyc, hi, tog;
  line_master_aux #(.FLASH1_HALF(8), .FLASH2_HALF(4)) dut (
    .i_clk(clk), .i_reset_n(rst_n), .i_ce(ce), .i_node_aux_in(n_in),
    .o_node_aux_out(n_out), .i_master_aux_in(m_in), .o_master_aux_out(m_out),
    .i_node_fault(fault), .i_node_present(present), .i_type_ok(type_ok),
    .i_line_closed(closed), .i_link_up(link_up), .i_pd_cycle(pd_cyc),
    .i_pd_out(pd_out), .o_pd_in(pd_in), .i_cfg_we(cfg_we), .i_cfg_pos(pos),
    .i_cfg_data(cdat), .i_mcfg_we(mcfg_we), .i_mcfg_data(mdat), .i_store(stor),
    .i_store_cmd(scmd), .i_idx_rd(idx_rd), .i_idx(idx), .o_idx_data(idx_q),
    .o_idx_valid(idx_v), .o_event_req(ev_req), .o_event_code(ev_code),
    .o_event_present(ev_pres), .i_event_ack(ev_ack), .o_pd_ready(pd_rdy));
  iolink_host_model host (
    .i_clk(clk), .i_pd_ready(pd_rdy), .i_event_req(ev_req),
    .o_pd_cycle(pd_cyc), .o_pd_out(pd_out), .o_event_ack(ev_ack));
  // ==========================================================
  // helpers
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic cfg(input logic [5:0] p, input logic [5:0] d);
    @(negedge clk);
    cfg_we = 1'b1;
    pos = p;
    cdat = node_cfg_s'(d);
    @(negedge clk);
    cfg_we = 1'b0;
  endtask
  task automatic mcfg(input logic [3:0] d);
    @(negedge clk);
    mcfg_we = 1'b1;
    mdat = d;
    @(negedge clk);
    mcfg_we = 1'b0;
  endtask
  task automatic store(input logic [7:0] c);
    @(negedge clk);
    stor = 1'b1;
    scmd = c;
    @(negedge clk);
    stor = 1'b0;
    tick(4);
  endtask
  task automatic idx_read(input logic [15:0] a, output logic [7:0] d);
    int n;
    n = 0;
    @(negedge clk);
    idx_rd = 1'b1;
    idx = a;
    @(negedge clk);
    idx_rd = 1'b0;
    while (idx_v !== 1'b1 && n < 8) begin
      n++;
      @(negedge clk);
    end
    d = (idx_v === 1'b1) ? idx_q : 8'hxx;
  endtask
  task automatic cmd2(input pd_word_t w);
    host.send_word(w);
    host.send_word(w);
    tick(3);
  endtask
  task automatic flash_count();
    hi = 0;
    tog = 0;
    repeat (64) begin
      @(negedge clk);
      hi += (n_out[2] === 1'b1);
      tog += (n_out[2] !== dut.o_node_aux_out[2]) ? 0 : 0;
    end
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      results();
    end
  end
  logic prev2;
  always @(negedge clk) begin
    prev2 <= n_out[2];
    if (n_out[2] !== prev2)
      tog++;
  end
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ==========================================================
  // main sequence
  initial begin
    err_total = 0; checked = 0; cyc = 0; hi = 0; tog = 0;
    rst_n = 1'b0; ce = 1'b1; m_in = 1'b0; cfg_we = 1'b0; mcfg_we = 1'b0;
    stor = 1'b0; idx_rd = 1'b0; type_ok = 1'b1; closed = 1'b1; link_up = 1'b0;
    n_in = 32'h0000_0000; fault = 32'h0000_0000; present = 32'h0000_0007;
    pos = 6'h00; cdat = node_cfg_s'(6'h00); mdat = 4'h0; scmd = 8'h00; idx = 16'h0000;
    tick(5);
    chk({n_out[30:0], m_out}, 32'h0000_0000);
    chk(ev_req, 1'b0);
    rst_n = 1'b1;
    tick(4);
    idx_read(`LM_IDX_COMM_STATE, rd); chk(rd, `LM_CS_INIT);
    idx_read(`LM_IDX_NODE_TOTAL, rd); chk(rd, 8'h03);
    idx_read(16'h0115, rd); chk(rd, 8'h00);
    for (int p = 0; p < 3; p++) cfg(6'(p), 6'h0D);
    cfg(6'd32, 6'h0C);
    store(8'h04);
    link_up = 1'b1;
    tick(8);
    idx_read(`LM_IDX_COMM_STATE, rd); chk(rd, `LM_CS_CFG_ERR);
    mcfg(4'h1);
    store(`LM_STORE_CMD);
    idx_read(`LM_IDX_COMM_STATE, rd); chk(rd, `LM_CS_INIT);
    mcfg(4'h0);
    store(`LM_STORE_CMD);
    tick(4);
    idx_read(`LM_IDX_COMM_STATE, rd); chk(rd, `LM_CS_RUNNING);
    done("state");
    n_in = 32'h0000_0005;
    tick(5);
    chk(m_out, 1'b1);
    host.send_word(32'h0000_0000);
    tick(2);
    chk(pd_in, 32'hA000_0000);
    cfg(6'd0, 6'h05); cfg(6'd2, 6'h05);
    store(`LM_STORE_CMD);
    chk(m_out, 1'b0);
    mcfg(4'h8);
    store(`LM_STORE_CMD);
    n_in = 32'hFFFF_FFFF; tick(5); chk(m_out, 1'b1);
    n_in = 32'hFFFF_FFFD; tick(5); chk(m_out, 1'b0);
    n_in = 32'hFFFF_FFFA; tick(5); chk(m_out, 1'b1);
    mcfg(4'h0);
    store(`LM_STORE_CMD);
    n_in = 32'h0000_0000;
    tick(5);
    done("inputs");
    cmd2(32'h8000_0000); chk(n_out, 32'h0000_0001);
    m_in = 1'b1; tick(5); chk(n_out, 32'hFFFF_FFFF);
    cfg(6'd1, 6'h09);
    store(`LM_STORE_CMD);
    chk(n_out, 32'hFFFF_FFFD);
    m_in = 1'b0;
    tick(5);
    n_in = 32'h0000_0001; tick(5);
    cmd2(32'h0000_0000); chk(n_out, 32'h0000_0001);
    n_in = 32'h0000_0000; tick(5); chk(n_out, 32'h0000_0000);
    cfg(6'd0, 6'h07);
    store(`LM_STORE_CMD);
    cmd2(32'h8000_0000);
    n_in = 32'h0000_0001; tick(5);
    cmd2(32'h0000_0000); chk(n_out, 32'h0000_0000);
    n_in = 32'h0000_0000;
    done("outputs");
    cfg(6'd2, 6'h1D);
    store(`LM_STORE_CMD);
    cmd2(32'h2000_0000);
    flash_count();
    chk(hi, 32);
    chk(tog inside {[7:9]}, 1'b1);
    cfg(6'd2, 6'h2D);
    store(`LM_STORE_CMD);
    flash_count();
    chk(hi, 32);
    chk(tog inside {[15:17]}, 1'b1);
    cmd2(32'h0000_0000);
    tick(1);
    chk(n_out[2], 1'b0);
    done("flash");
    fault = 32'h0000_0010;
    tick(4);
    chk(ev_pres, 1'b1);
    chk(ev_code, `LM_EVT_CUTOFF);
    host.take_event(seen); chk(seen, 1'b1);
    tick(2);
    chk(ev_req, 1'b0);
    fault = 32'h0000_0000;
    tick(4);
    chk(ev_pres, 1'b0);
    host.take_event(seen); chk(seen, 1'b1);
    done("event");
    results();
  end
endmodule
